// ### hdl/mains_locked_timing_and_fsk_synth.sv
`timescale 1ns/1ps

// =========================================================
// Transmit byte FIFO
// =========================================================
module tx_byte_fifo #(
    parameter int unsigned WIDTH = 8,
    parameter int unsigned DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             srst,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int unsigned AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;     // Storage words
        logic [AW-1:0]               wr_ptr;  // Next write slot
        logic [AW-1:0]               rd_ptr;  // Next read slot
        logic [AW:0]                 count;   // Words held
        logic                        ready;   // Not full, registered
    } fifo_state_t;

    fifo_state_t s_ff;      // Current state
    fifo_state_t nxt_s;     // Next state
    logic        push;      // Accepted write
    logic        pop;       // Accepted read

    assign push      = in_valid && s_ff.ready;
    assign pop       = out_ready && (s_ff.count != '0);
    assign in_ready  = s_ff.ready;
    assign out_valid = (s_ff.count != '0);
    assign out_data  = s_ff.mem[s_ff.rd_ptr];

    // Pointer and count update
    always_comb begin
        nxt_s = s_ff;
        if (push) begin
            nxt_s.mem[s_ff.wr_ptr] = in_data;
            nxt_s.wr_ptr           = AW'(s_ff.wr_ptr + 1'b1);
        end
        if (pop) begin
            nxt_s.rd_ptr = AW'(s_ff.rd_ptr + 1'b1);
        end
        if (push && !pop) begin
            nxt_s.count = s_ff.count + 1'b1;
        end else if (pop && !push) begin
            nxt_s.count = s_ff.count - 1'b1;
        end
        nxt_s.ready = (nxt_s.count != (AW+1)'(DEPTH));
    end

    // State register
    always_ff @(posedge clk) begin
        if (srst) begin
            s_ff       <= '0;
            s_ff.ready <= 1'b1;
        end else begin
            s_ff <= nxt_s;
        end
    end

endmodule : tx_byte_fifo

// =========================================================
// Mains locked timing and FSK synthesizer
// =========================================================
module mains_locked_timing_and_fsk_synth
    import mains_timing_pkg::*;
#(
    parameter int unsigned PERIOD_50_CYCLES = mains_timing_pkg::mains50_cycles,
    parameter int unsigned PERIOD_60_CYCLES = mains_timing_pkg::mains60_cycles,
    parameter int unsigned FIFO_DEPTH       = mains_timing_pkg::fifo_depth
) (
    input  wire logic        clk,
    input  wire logic        srst,
    input  wire logic        mains_sense_input,
    input  wire logic        transmit_select_flag,
    input  wire logic        wr_en,
    input  wire logic [2:0]  wr_addr,
    input  wire logic [15:0] wr_data,
    input  wire logic [2:0]  rd_addr,
    output logic      [15:0] rd_data,
    output logic             tx_buffer_ready,
    output logic             chip_tick,
    output logic             bit_strobe,
    output logic             byte_strobe,
    output logic             frame_strobe,
    output logic             early_byte_strobe,
    output logic             early_frame_strobe,
    output logic             pre_slot,
    output logic             shared_warning_output_pin,
    output logic             tx_clk_tick,
    output logic             rx_clk_tick,
    output logic             synthesizer_clock,
    output logic             dds_active,
    output logic      [17:0] dds_phase
);
    import mains_timing_pkg::*;

    // =====================================================
    // State
    // =====================================================
    typedef struct packed {
        logic        sense_s1;    // Synchroniser first stage
        logic        sense_s2;    // Synchroniser second stage
        logic        sense_prev;  // Previous synchronised level
        logic [7:0]  config_r;    // modem_configuration
        logic [7:0]  advance;     // zero_cross_phase_advance
        logic [7:0]  txbuf;       // transmit_bit_buffer, last written
        logic [15:0] mark;        // mark_frequency_step
        logic [15:0] space;       // space_frequency_step
        logic [23:0] period;      // Measured mains period in clocks
        logic [23:0] since_edge;  // Clocks since last rising edge
        logic [23:0] countdown;   // Clocks to next chip realignment
        logic [24:0] chip_acc;    // Fractional chip accumulator
        logic [8:0]  chips_done;  // Chips issued this mains period
        logic [11:0] chip_cnt;    // Subframe chip counter
        logic        chip_stb;    // Chip tick pulse
        logic        bit_stb;     // Bit strobe pulse
        logic        byte_stb;    // Byte strobe pulse
        logic        frame_stb;   // Frame strobe pulse
        logic        pre_byte;    // Early byte strobe pulse
        logic        pre_frame;   // Early frame strobe pulse
        logic        pre_slot;    // Pre-slot level
        logic        pin;         // Shared output pin level
        logic [7:0]  base_acc;    // Base clock fractional accumulator
        logic [3:0]  base_div;    // Base tick divider
        logic        tx_tick;     // Transmit clock tick
        logic        rx_tick;     // Receive clock tick
        logic        synth_tick;  // Synthesizer clock tick
        logic        tx_prev;     // Mode flag last cycle
        logic        dds_run;     // Synthesizer producing output
        logic [17:0] phase;       // Phase accumulator
        logic [7:0]  shift;       // Bits of byte being sent
        logic        cur_bit;     // Bit on air
        logic [15:0] rd_data;     // Read data register
    } top_state_t;

    top_state_t  s_ff;         // Current state
    top_state_t  nxt_s;        // Next state

    logic        rise;         // Rising comparator edge
    logic [23:0] nominal;      // Nominal mains period
    logic [23:0] interval;     // Length of period just ended
    logic        edge_ok;      // Edge inside plausible window
    logic [23:0] adv_cycles;   // Advance in clocks
    logic [8:0]  chips;        // Chips per mains period
    logic        realign;      // Chip phase realignment
    logic [24:0] acc_sum;      // Accumulator plus increment
    logic        acc_tick;     // Chip from the accumulator
    logic        tick;         // Any chip tick
    logic [11:0] nxt_cnt;      // Chip counter after a tick
    logic        byte_edge;    // Byte boundary this tick
    logic        fifo_in_valid; // Write to transmit buffer
    logic        fifo_valid;   // Byte waiting
    logic        fifo_pop;     // Take next byte
    logic [7:0]  fifo_data;    // Byte at FIFO head
    logic [8:0]  base_sum;     // Base accumulator plus step, with carry
    logic        base_tick;    // 48 MHz equivalent tick
    logic [18:0] phase_sum;    // Phase plus step, with carry
    logic [15:0] step;         // Step for bit on air

    // =====================================================
    // Derived terms
    // =====================================================
    assign rise       = s_ff.sense_s2 && !s_ff.sense_prev;
    assign nominal    = s_ff.config_r[cfg_mains_bit] ? 24'(PERIOD_60_CYCLES)
                                                     : 24'(PERIOD_50_CYCLES);
    assign interval   = s_ff.since_edge + 24'd1;
    assign edge_ok    = rise && (interval > (nominal >> 1))
                        && (interval < (nominal + (nominal >> 1)));
    assign adv_cycles = 24'(s_ff.advance) * 24'(adv_step_cycles);
    assign chips      = 9'(base_chips_per_period)
                        << s_ff.config_r[cfg_rate_msb:cfg_rate_lsb];
    assign realign    = (s_ff.countdown == 24'd1);
    assign acc_sum    = s_ff.chip_acc + 25'(chips);
    assign acc_tick   = (acc_sum >= {1'b0, s_ff.period}) && (s_ff.chips_done < chips);
    assign tick       = realign || acc_tick;
    assign nxt_cnt    = (s_ff.chip_cnt == 12'(chips_per_frame - 1)) ? 12'd0
                        : 12'(s_ff.chip_cnt + 12'd1);
    assign byte_edge  = tick && ((nxt_cnt % 12'(chips_per_byte)) == 12'd0);
    assign fifo_pop   = byte_edge && transmit_select_flag && fifo_valid;
    assign fifo_in_valid = wr_en && (wr_addr == idx_txbuf);
    assign base_sum   = 9'(s_ff.base_acc) + 9'(base_acc_step);
    assign base_tick  = (base_sum >= 9'(base_acc_modulo));
    assign step       = s_ff.cur_bit ? s_ff.mark : s_ff.space;
    assign phase_sum  = {1'b0, s_ff.phase} + 19'(step);

    // =====================================================
    // Transmit byte buffer
    // =====================================================
    tx_byte_fifo #(
        .WIDTH (8),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .clk       (clk),
        .srst      (srst),
        .in_valid  (fifo_in_valid),
        .in_ready  (tx_buffer_ready),
        .in_data   (wr_data[7:0]),
        .out_valid (fifo_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_data)
    );

    // =====================================================
    // Next state
    // =====================================================
    always_comb begin
        nxt_s = s_ff;

        // Mains sense synchroniser
        nxt_s.sense_s1   = mains_sense_input;
        nxt_s.sense_s2   = s_ff.sense_s1;
        nxt_s.sense_prev = s_ff.sense_s2;

        // Register writes
        if (wr_en) begin
            case (wr_addr)
                idx_config:  nxt_s.config_r = wr_data[7:0];
                idx_advance: nxt_s.advance  = wr_data[7:0];
                idx_txbuf:   nxt_s.txbuf    = wr_data[7:0];
                idx_mark:    nxt_s.mark     = wr_data;
                idx_space:   nxt_s.space    = wr_data;
                default:     nxt_s.rd_data  = s_ff.rd_data;
            endcase
        end

        // Edge timer saturates while crossings are missing
        if (rise) begin
            nxt_s.since_edge = 24'd0;
        end else if (s_ff.since_edge != 24'hFF_FFFF) begin
            nxt_s.since_edge = interval;
        end

        // Period capture and realignment countdown
        if (edge_ok) begin
            nxt_s.period    = interval;
            nxt_s.countdown = (interval > adv_cycles) ? 24'(interval - adv_cycles)
                                                      : 24'd1;
        end else if (realign) begin
            nxt_s.countdown = s_ff.period; // Flywheel on held period
        end else begin
            nxt_s.countdown = s_ff.countdown - 24'd1;
        end

        // Fractional chip generator
        if (realign) begin
            nxt_s.chip_acc   = 25'd0;
            nxt_s.chips_done = 9'd1;
        end else if (acc_tick) begin
            nxt_s.chip_acc   = acc_sum - {1'b0, s_ff.period};
            nxt_s.chips_done = s_ff.chips_done + 9'd1;
        end else if (s_ff.chips_done < chips) begin
            nxt_s.chip_acc = acc_sum;
        end

        // Chip counter never touched by mode changes
        if (tick) begin
            nxt_s.chip_cnt = nxt_cnt;
        end
        nxt_s.chip_stb  = tick;
        nxt_s.bit_stb   = tick && ((nxt_cnt % 12'(chips_per_bit)) == 12'd0);
        nxt_s.byte_stb  = byte_edge;
        nxt_s.frame_stb = tick && (nxt_cnt == 12'd0);
        nxt_s.pre_byte  = tick && ((nxt_cnt % 12'(chips_per_byte))
                          == 12'(chips_per_byte - early_chips));
        nxt_s.pre_frame = tick && (nxt_cnt == 12'(chips_per_frame - early_chips));

        // Pre-slot window
        if (nxt_s.pre_frame) begin
            nxt_s.pre_slot = 1'b1;
        end else if (nxt_s.frame_stb) begin
            nxt_s.pre_slot = 1'b0;
        end
        nxt_s.pin = s_ff.config_r[cfg_pin_bit] ? s_ff.cur_bit : nxt_s.pre_slot;

        // Base, transmit, receive and synthesizer ticks
        nxt_s.tx_tick    = 1'b0;
        nxt_s.rx_tick    = 1'b0;
        nxt_s.synth_tick = 1'b0;
        if (base_tick) begin
            nxt_s.base_acc   = 8'(base_sum - 9'(base_acc_modulo));
            nxt_s.base_div   = s_ff.base_div + 4'd1;
            nxt_s.tx_tick    = (s_ff.base_div[1:0] == 2'(tx_div - 1));
            nxt_s.rx_tick    = (s_ff.base_div[2:0] == 3'(rx_div - 1));
            nxt_s.synth_tick = (s_ff.base_div == 4'(synth_div - 1));
        end else begin
            nxt_s.base_acc = base_sum[7:0];
        end

        // Bit shifter, MSB first; idle sends space bits
        if (tick && transmit_select_flag) begin
            if (byte_edge) begin
                nxt_s.cur_bit = fifo_valid ? fifo_data[7] : 1'b0;
                nxt_s.shift   = fifo_valid ? {fifo_data[6:0], 1'b0} : 8'h00;
            end else if (nxt_s.bit_stb) begin
                nxt_s.cur_bit = s_ff.shift[7];
                nxt_s.shift   = {s_ff.shift[6:0], 1'b0};
            end
        end

        // Phase accumulator
        nxt_s.tx_prev = transmit_select_flag;
        if (transmit_select_flag && !s_ff.tx_prev) begin
            nxt_s.phase   = 18'd0; // Start from zero level
            nxt_s.dds_run = 1'b1;
        end else if (s_ff.dds_run && s_ff.synth_tick) begin
            nxt_s.phase = phase_sum[17:0]; // Continuous across bits
            if (!transmit_select_flag && phase_sum[18]) begin
                nxt_s.phase   = 18'd0; // Period done, stop
                nxt_s.dds_run = 1'b0;
            end
        end

        // Read data
        case (rd_addr)
            idx_config:  nxt_s.rd_data = {8'h00, s_ff.config_r};
            idx_advance: nxt_s.rd_data = {8'h00, s_ff.advance};
            idx_txbuf:   nxt_s.rd_data = {8'h00, s_ff.txbuf};
            idx_mark:    nxt_s.rd_data = s_ff.mark;
            idx_space:   nxt_s.rd_data = s_ff.space;
            idx_status:  nxt_s.rd_data = {s_ff.dds_run, s_ff.pre_slot, 2'b00, s_ff.chip_cnt};
            default:     nxt_s.rd_data = 16'h0000;
        endcase
    end

    // =====================================================
    // State register
    // =====================================================
    always_ff @(posedge clk) begin
        if (srst) begin
            s_ff           <= '0;
            s_ff.config_r  <= config_reset;
            s_ff.advance   <= advance_reset;
            s_ff.txbuf     <= txbuf_reset;
            s_ff.mark      <= step_reset;
            s_ff.space     <= step_reset;
            s_ff.period    <= 24'(PERIOD_50_CYCLES);
            s_ff.countdown <= 24'(PERIOD_50_CYCLES);
        end else begin
            s_ff <= nxt_s;
        end
    end

    // =====================================================
    // Outputs
    // =====================================================
    assign rd_data                   = s_ff.rd_data;
    assign chip_tick                 = s_ff.chip_stb;
    assign bit_strobe                = s_ff.bit_stb;
    assign byte_strobe               = s_ff.byte_stb;
    assign frame_strobe              = s_ff.frame_stb;
    assign early_byte_strobe         = s_ff.pre_byte;
    assign early_frame_strobe        = s_ff.pre_frame;
    assign pre_slot                  = s_ff.pre_slot;
    assign shared_warning_output_pin = s_ff.pin;
    assign tx_clk_tick               = s_ff.tx_tick;
    assign rx_clk_tick               = s_ff.rx_tick;
    assign synthesizer_clock         = s_ff.synth_tick;
    assign dds_active                = s_ff.dds_run;
    assign dds_phase                 = s_ff.phase;

endmodule : mains_locked_timing_and_fsk_synth

// ### pkg/mains_timing_pkg.sv
// Summary of operation
// - Chip clock from comparator rising edges, 8x bitrate
// - Configuration bit 0 picks 50 or 60 Hz
// - Configuration bits 2:1 pick 6/12/24/48 bits
// - Chip clock rate follows mains and bitrate code
// - Loop tracks rising edges only, stays in phase
// - Missing crossings hold the period, chip clock flywheels
// - Phase advance register, 13 us steps, resets zero
// - Chip counter kept across transmit/receive switches
// - Bit strobe at every multiple of 8
// - Byte strobe at every multiple of 64
// - Frame strobe only at counter zero
// - Early byte strobe eight chips before byte strobe
// - Early frame strobe eight chips before frame
// - Pre-slot level on shared pin when bit7 clear
// - Mode flag high transmits; modulator idle on receive
// - Eight-bit transmit data register holds bits
// - Space step for 0, mark step for 1
// - Step added each synthesizer tick, 18-bit accumulator
// - Accumulator cleared at start; switching phase-continuous
// - On receive, finish current sine period then stop
// - 48 MHz base, transmit /4, receive /8 ticks
package mains_timing_pkg;

    // =====================================================
    // Clock and timing
    // =====================================================
    localparam int unsigned clk_hz            = 250_000_000; // System clock rate
    localparam int unsigned base_hz           = 48_000_000;  // Modem base clock rate
    localparam int unsigned base_acc_modulo   = clk_hz / 1_000_000;  // 250
    localparam int unsigned base_acc_step     = base_hz / 1_000_000; // 48
    localparam int unsigned tx_div            = 4;           // Transmit tick divider
    localparam int unsigned rx_div            = 8;           // Receive tick divider
    localparam int unsigned synth_div         = 16;          // 3 MHz synthesizer tick
    localparam int unsigned adv_step_ns       = 13_000;      // Phase advance granularity
    localparam int unsigned adv_step_cycles   = (adv_step_ns * (clk_hz / 1_000_000)) / 1000;
    localparam int unsigned mains50_period_us = 20_000;      // 50 Hz period
    localparam int unsigned mains60_period_us = 16_667;      // 60 Hz period
    localparam int unsigned mains50_cycles    = mains50_period_us * (clk_hz / 1_000_000);
    localparam int unsigned mains60_cycles    = mains60_period_us * (clk_hz / 1_000_000);

    // =====================================================
    // Frame structure
    // =====================================================
    localparam int unsigned chips_per_bit         = 8;    // Chip clocks per bit
    localparam int unsigned chips_per_byte        = 64;   // Chip clocks per byte
    localparam int unsigned chips_per_frame       = 2880; // Chip clocks per subframe
    localparam int unsigned early_chips           = 8;    // Early strobe lead
    localparam int unsigned base_chips_per_period = 48;   // 6 bits times 8 chips

    // =====================================================
    // Register indices
    // =====================================================
    localparam logic [2:0] idx_config  = 3'h0; // modem_configuration
    localparam logic [2:0] idx_advance = 3'h1; // zero_cross_phase_advance
    localparam logic [2:0] idx_txbuf   = 3'h2; // transmit_bit_buffer
    localparam logic [2:0] idx_mark    = 3'h3; // mark_frequency_step
    localparam logic [2:0] idx_space   = 3'h4; // space_frequency_step
    localparam logic [2:0] idx_status  = 3'h5; // Chip counter and mode status

    // =====================================================
    // Field positions and reset values
    // =====================================================
    localparam int unsigned cfg_mains_bit = 0; // 0 = 50 Hz, 1 = 60 Hz
    localparam int unsigned cfg_rate_lsb  = 1; // Bitrate code low bit
    localparam int unsigned cfg_rate_msb  = 2; // Bitrate code high bit
    localparam int unsigned cfg_pin_bit   = 7; // 0 = pre-slot on shared pin
    localparam logic [7:0]  config_reset  = 8'h00;
    localparam logic [7:0]  advance_reset = 8'h00;
    localparam logic [7:0]  txbuf_reset   = 8'h00;
    localparam logic [15:0] step_reset    = 16'h0000;
    localparam int unsigned fifo_depth    = 16; // Transmit byte FIFO depth
    localparam int unsigned dds_width     = 18; // Phase accumulator width

endpackage : mains_timing_pkg

// ### tb/core_model.sv
`timescale 1ns/1ps

// ==========================================
// Processor core model: register writes
module core_model (
    input  wire logic        clk,
    output logic             wr_en   = 1'b0,
    output logic      [2:0]  wr_addr = 3'h0,
    output logic      [15:0] wr_data = 16'h0000
);
    // One write strobe, raised and dropped on falling edges
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(negedge clk);
        wr_en   = 1'b1;
        wr_addr = a;
        wr_data = d;
        @(negedge clk);
        wr_en = 1'b0;
    endtask : wr
endmodule : core_model

// ### tb/mains_timing_monitor.sv
`timescale 1ns/1ps

// ==========================================
// Strobe and synthesizer checks
module mains_timing_monitor (
    input wire logic        clk,
    input wire logic        srst,
    input wire logic        transmit_select_flag,
    input wire logic        chip_tick,
    input wire logic        bit_strobe,
    input wire logic        byte_strobe,
    input wire logic        frame_strobe,
    input wire logic        early_byte_strobe,
    input wire logic        early_frame_strobe,
    input wire logic        pre_slot,
    input wire logic        tx_clk_tick,
    input wire logic        rx_clk_tick,
    input wire logic        synthesizer_clock,
    input wire logic        dds_active,
    input wire logic [17:0] dds_phase
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);
    property p_bit; bit_strobe |-> chip_tick; endproperty
    a_bit: assert property (p_bit) else $error("bit strobe off tick");
    property p_frm; frame_strobe |-> byte_strobe && bit_strobe; endproperty
    a_frm: assert property (p_frm) else $error("frame strobe off byte");
    property p_eby; early_byte_strobe |-> bit_strobe && !byte_strobe; endproperty
    a_eby: assert property (p_eby) else $error("early byte misplaced");
    property p_efr; early_frame_strobe |-> early_byte_strobe && pre_slot; endproperty
    a_efr: assert property (p_efr) else $error("early frame misplaced");
    property p_slot; frame_strobe |-> !pre_slot ##1 !pre_slot; endproperty
    a_slot: assert property (p_slot) else $error("pre-slot past frame");
    property p_idle; !transmit_select_flag && !dds_active |=> !dds_active; endproperty
    a_idle: assert property (p_idle) else $error("synth runs in receive");
    property p_stop; $fell(dds_active) |-> dds_phase == 18'h0_0000; endproperty
    a_stop: assert property (p_stop) else $error("stop off period end");
    property p_syn; synthesizer_clock |=> !synthesizer_clock [*8]; endproperty
    a_syn: assert property (p_syn) else $error("synth tick too fast");
    property p_rxt; rx_clk_tick |-> tx_clk_tick; endproperty
    a_rxt: assert property (p_rxt) else $error("receive tick off transmit tick");
    property p_stk; synthesizer_clock |-> rx_clk_tick; endproperty
    a_stk: assert property (p_stk) else $error("synth tick off receive tick");
    cover property (early_frame_strobe ##1 pre_slot);
    cover property ($fell(dds_active));
    cover property (transmit_select_flag && synthesizer_clock);
endmodule : mains_timing_monitor

bind mains_locked_timing_and_fsk_synth mains_timing_monitor mon (.*);

// ### tb/mains_locked_timing_and_fsk_synth_tb_top.sv
`timescale 1ns/1ps

// ==========================================
// Bench top
module mains_locked_timing_and_fsk_synth_tb_top;
    import mains_timing_pkg::*;
    localparam int unsigned per = 4000; // Short mains period in clocks
    logic clk = 1'b0, srst = 1'b1, mains = 1'b0, run = 1'b1, txf = 1'b0;
    logic [2:0]  rd_addr = 3'h0, wr_addr;
    logic [15:0] rd_data, wr_data;
    logic        wr_en, ct, bs, ys, fs, eb, ef, ps, sp, sc, act, rdy;
    logic [17:0] ph, a;
    wire  [6:0]  tv = {sp, ps, ef, eb, ys, bs, ct}; // Counted outputs
    int          failures = 0, checks_done = 0, cyc = 0;
    always #2 clk = ~clk;
    always #(per * 2) mains = run ? ~mains : 1'b0; // Comparator square wave
    always @(posedge clk) begin // Watchdog
        cyc <= cyc + 1;
        if (cyc == 99000) begin
            failures = failures + 1;
            stop_test();
        end
    end
    core_model core (.clk(clk), .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data));
    mains_locked_timing_and_fsk_synth #(.PERIOD_50_CYCLES(per), .PERIOD_60_CYCLES(3333))
    dut (.clk(clk), .srst(srst), .mains_sense_input(mains), .transmit_select_flag(txf),
        .wr_en(wr_en), .wr_addr(wr_addr), .wr_data(wr_data), .rd_addr(rd_addr),
        .rd_data(rd_data), .tx_buffer_ready(rdy), .chip_tick(ct), .bit_strobe(bs),
        .byte_strobe(ys), .frame_strobe(fs), .early_byte_strobe(eb),
        .early_frame_strobe(ef), .pre_slot(ps), .shared_warning_output_pin(sp),
        .tx_clk_tick(), .rx_clk_tick(), .synthesizer_clock(sc), .dds_active(act),
        .dds_phase(ph));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks_done = checks_done + 1;
        if (seen !== exp) begin
            failures = failures + 1;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test();
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : stop_test
    task automatic sync(ref logic s); // Pulse seen, then one edge on
        while (s !== 1'b1) @(negedge clk);
        @(negedge clk);
    endtask : sync
    task automatic t_regs(); // Reset values, readback, unmapped index last
        logic [15:0] w [6] = '{16'h0006, 16'h00FF, 16'h005A, 16'h2000, 16'h1000, 16'hFFFF};
        for (int i = 0; i < 6; i++) begin
            rd_addr = (i == 5) ? 3'h6 : 3'(i);
            @(negedge clk);
            chk(rd_data, 0);
            core.wr(rd_addr, w[i]);
            @(negedge clk);
            chk(rd_data, (i == 5) ? 16'h0000 : w[i]);
        end
        core.wr(idx_advance, 16'h0000);
        chk(rdy, 1);
        repeat (15) core.wr(idx_txbuf, 16'h0000);
        chk(rdy, 0);
    endtask : t_regs
    task automatic t_frame(); // One frame of strobes, mode flipped mid-frame
        int n [7] = '{default: 0};
        int c = 0;
        sync(fs);
        while (fs !== 1'b1) begin
            foreach (n[j]) n[j] += tv[j];
            if (ef === 1'b1) c = n[0];
            if (ct === 1'b1 && n[0] == 1000) txf = 1'b1;
            @(negedge clk);
        end
        chk(n[0], 2879);
        chk(n[1], 359);
        chk(n[2], 44);
        chk(n[3], 45);
        chk(n[4], 1);
        chk(n[0] - c, 7);
        chk(n[5] > 40 && n[5] - n[6] < 2, 1);
        rd_addr = idx_status;
        @(negedge clk);
        chk(rd_data, 16'h8000);
    endtask : t_frame
    task automatic t_dds(); // Stop, restart at zero, space then mark steps
        txf = 1'b0;
        while (act !== 1'b0) @(negedge clk);
        chk(ph, 0);
        txf = 1'b1;
        repeat (2) @(negedge clk);
        chk(act, 1);
        chk(ph <= 18'h0_1000, 1);
        sync(sc);
        a = ph;
        sync(sc);
        chk(18'(ph - a), 16'h1000);
        repeat (3) core.wr(idx_txbuf, 16'h00FF);
        sync(ys);
        sync(ys);
        sync(sc);
        a = ph;
        sync(sc);
        chk(18'(ph - a), 16'h2000);
        core.wr(idx_config, 16'h0086);
        @(negedge clk);
        chk(sp, 1);
    endtask : t_dds
    task automatic t_freeze(); // Mains gone: ticks keep the learned rate
        int n = 0;
        run = 1'b0;
        repeat (2 * per) begin
            @(negedge clk);
            n += ct;
        end
        chk(n >= 760 && n <= 776, 1);
    endtask : t_freeze
    initial begin
        repeat (3) @(negedge clk);
        srst = 1'b0;
        t_regs();
        t_frame();
        t_dds();
        t_freeze();
        stop_test();
    end
endmodule : mains_locked_timing_and_fsk_synth_tb_top
